// ===== include/upar_pkg.sv
// constants, register map and state types of the usb phy auxiliary register bank
package upar_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_PWR      = 8'hac;
	localparam logic [7:0] ADDR_PWR_SET  = 8'had;
	localparam logic [7:0] ADDR_PWR_CLR  = 8'hae;
	localparam logic [7:0] ADDR_IFC      = 8'haf;
	localparam logic [7:0] ADDR_IFC_SET  = 8'hb0;
	localparam logic [7:0] ADDR_IFC_CLR  = 8'hb1;
	localparam logic [7:0] ADDR_EN       = 8'hb2;
	localparam logic [7:0] ADDR_EN_SET   = 8'hb3;
	localparam logic [7:0] ADDR_EN_CLR   = 8'hb4;
	localparam logic [7:0] ADDR_ERR      = 8'hb5;
	localparam logic [7:0] ADDR_TRIM     = 8'hb8;
	localparam logic [7:0] ADDR_TRIM_SET = 8'hb9;
	localparam logic [7:0] ADDR_TRIM_CLR = 8'hba;

	// implemented bits per register
	localparam logic [7:0] PWR_MASK  = 8'h2f;
	localparam logic [7:0] IFC_MASK  = 8'h1f;
	localparam logic [7:0] EN_MASK   = 8'h01;
	localparam logic [7:0] TRIM_MASK = 8'hfd;

	// values after reset
	localparam logic [7:0] PWR_RST  = 8'h00;
	localparam logic [7:0] IFC_RST  = 8'h00;
	localparam logic [7:0] EN_RST   = 8'h00;
	localparam logic [7:0] ERR_RST  = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h04;

	// field positions
	localparam int OTG_ON_BIT   = 5;
	localparam int STOP_LOW_BIT = 4;
	localparam int TX_POL_BIT   = 3;
	localparam int FOUR_PIN_BIT = 2;
	localparam int ROUTE_LSB    = 0;
	localparam int COLL_BIT     = 0;
	localparam int ZTRIM_LSB    = 6;
	localparam int ITRIM_LSB    = 2;
	localparam int VBAT_BIT     = 0;

	// interrupt route codes
	localparam logic [1:0] ROUTE_PROC1 = 2'h0;
	localparam logic [1:0] ROUTE_PROC2 = 2'h1;

	typedef enum logic [2:0] {REG_NONE, REG_PWR, REG_IFC, REG_EN, REG_ERR, REG_TRIM} upar_reg_t;
	typedef enum logic [1:0] {OP_BASE, OP_SET, OP_CLR} upar_op_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} upar_acc_t;

	typedef struct packed {
		logic [7:0] pwr;
		logic [7:0] ifc;
		logic [7:0] en;
		logic [7:0] err;
		logic [7:0] trim;
		logic [7:0] i2c_rdata;
		logic [7:0] ulpi_rdata;
		logic       ulpi_pend;
		upar_acc_t  ulpi_acc;
		logic       ack_tgl;
		logic [2:0] req_sync;
		logic       req_seen;
		logic [3:0] test_en;
		logic       stop_low;
		logic       txen;
		logic       irq1_n;
		logic       irq2_n;
		logic       coll_irq;
	} upar_main_t;

	typedef struct packed {
		logic       req_tgl;
		logic       busy;
		upar_acc_t  acc;
		logic [2:0] ack_sync;
		logic       ack_seen;
		logic [7:0] rdata;
		logic       done;
	} upar_link_t;

endpackage

// ===== verification/tb_upar_regs.sv
// self-checking bench of the usb phy auxiliary register bank
`timescale 1ns/1ps
module tb_upar_regs;
	import upar_pkg::*;
	logic       clk, rst, lclk, lrst, wr, rd, lreq, lwe, busy, done, gpio_mux, txen_in;
	logic       irq_in, alt_en, otg_block_enable, stop_low, txen_out, four_pin, irq1_n, irq2_n;
	logic       coll_irq, boost, vbat;
	logic [7:0] addr, wdata, rdata, laddr, lwdata, lrdata, got;
	logic [3:0] test_en, itrim;
	logic [1:0] ztrim;
	logic [7:0] base [4] = '{8'hac, 8'haf, 8'hb2, 8'hb8};
	logic [7:0] mask [4] = '{8'h2f, 8'h1f, 8'h01, 8'hfd};
	logic [1:0] route [4] = '{2'b01, 2'b10, 2'b11, 2'b11};
	int         miscompares = 0;
	int         tests_run = 0;

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #80 lclk = ~lclk;
	end

	upar_regs i_dut (
		.CLK_I(clk), .SYS_RST_I(rst), .I2C_ADDR_I(addr), .I2C_WDATA_I(wdata),
		.I2C_WR_I(wr), .I2C_RD_I(rd), .I2C_RDATA_O(rdata), .ULPI_CLK_I(lclk),
		.LINK_RST_I(lrst), .ULPI_REQ_I(lreq), .ULPI_WE_I(lwe), .ULPI_ADDR_I(laddr),
		.ULPI_WDATA_I(lwdata), .ULPI_RDATA_O(lrdata), .ULPI_DONE_O(done),
		.ULPI_BUSY_O(busy), .STOP_GPIO_MUX_I(gpio_mux), .SERIAL_TX_ENABLE_I(txen_in),
		.PHY_IRQ_I(irq_in), .ALT_ROUTE_EN_I(alt_en), .OTG_BLOCK_ENABLE_O(otg_block_enable),
		.TEST_EN_O(test_en), .STOP_FORCE_LOW_O(stop_low), .SERIAL_TX_ENABLE_O(txen_out),
		.FOUR_PIN_SERIAL_O(four_pin), .PROC1_IRQ_N_O(irq1_n), .PROC2_IRQ_N_O(irq2_n),
		.COLLISION_IRQ_O(coll_irq), .HS_IMPEDANCE_TRIM_O(ztrim), .HS_DRIVE_TRIM_O(itrim),
		.AC_BOOST_O(boost), .BATTERY_TIMER_EN_O(vbat)
	);

	upar_link_model i_link (
		.clk_i(lclk), .busy_i(busy), .done_i(done), .rdata_i(lrdata),
		.req_o(lreq), .we_o(lwe), .addr_o(laddr), .wdata_o(lwdata)
	);

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		{wr, addr, wdata} = {1'b1, a, d};
		@(posedge clk) #1;
		{wr, addr, wdata} = {1'b0, ~a, ~d};
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) #1;
		{rd, addr} = {1'b1, a};
		@(posedge clk) #1;
		{rd, addr} = {1'b0, ~a};
		chk(rdata, e);
	endtask
	// back-to-back i2c reads of the serial control register for n cycles
	task automatic burst(input int n);
		@(posedge clk) #1;
		{rd, addr} = {1'b1, ADDR_IFC};
		repeat (n) @(posedge clk);
		#1;
		{rd, addr} = {1'b0, ~ADDR_IFC};
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#2000000;
		miscompares++;
		complete_run();
	end

	initial begin
		{rst, lrst, wr, rd, addr, wdata} = {4'hc, 16'h0};
		{gpio_mux, txen_in, irq_in, alt_en} = 4'h0;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		repeat (2) @(posedge lclk);
		#1 lrst = 1'b0;
		for (int a = 'hac; a <= 'hba; a++)
			rd_chk(8'(a), (a >= 'hb8) ? 8'h04 : 8'h00);
		chk({irq1_n, irq2_n, ztrim, itrim}, 8'hc1);
		chk({6'h0, boost, vbat}, 8'h02);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			wr_reg(base[i], 8'hff);
			rd_chk(base[i], mask[i]);
			rd_chk(base[i] + 8'h2, mask[i]);
			wr_reg(base[i] + 8'h2, 8'hff);
			rd_chk(base[i], 8'h00);
			wr_reg(base[i] + 8'h1, 8'h50);
			wr_reg(base[i] + 8'h1, 8'h0a);
			rd_chk(base[i] + 8'h1, 8'h5a & mask[i]);
			wr_reg(base[i] + 8'h2, 8'h0a);
			rd_chk(base[i], 8'h50 & mask[i]);
		end
		$display("alias access done");
		wr_reg(ADDR_PWR, 8'h0f);
		settle();
		chk({otg_block_enable, 3'h0, test_en}, 8'h0f);
		wr_reg(ADDR_PWR_SET, 8'h20);
		settle();
		chk({otg_block_enable, 3'h0, test_en}, 8'h80);
		wr_reg(ADDR_IFC, 8'h00);
		{gpio_mux, txen_in, irq_in, alt_en} = 4'hf;
		settle();
		chk({stop_low, txen_out, four_pin, 5'h0}, 8'h40);
		wr_reg(ADDR_IFC, 8'h1c);
		settle();
		chk({stop_low, txen_out, four_pin, 5'h0}, 8'ha0);
		for (int c = 0; c < 4; c++) begin
			wr_reg(ADDR_IFC, 8'(c));
			settle();
			chk({6'h0, irq1_n, irq2_n}, {6'h0, route[c]});
		end
		alt_en = 1'b0;
		settle();
		chk({6'h0, irq1_n, irq2_n}, 8'h01);
		wr_reg(ADDR_TRIM, 8'hc1);
		settle();
		chk({ztrim, itrim, boost, vbat}, 8'hc1);
		wr_reg(ADDR_TRIM, 8'h3c);
		settle();
		chk({ztrim, itrim, boost, vbat}, 8'h3e);
		$display("control outputs done");
		i_link.access(1'b1, ADDR_IFC, 8'h13, 0, got);
		rd_chk(ADDR_IFC, 8'h13);
		i_link.access(1'b0, ADDR_IFC, 8'h00, 3, got);
		chk(got, 8'h13);
		i_link.access(1'b1, ADDR_TRIM_CLR, 8'hff, 0, got);
		rd_chk(ADDR_TRIM, 8'h3c);
		i_link.access(1'b0, ADDR_TRIM, 8'h00, 0, got);
		chk(got, 8'h00);
		$display("link access done");
		wr_reg(ADDR_EN, 8'h01);
		fork
			i_link.access(1'b0, ADDR_PWR, 8'h00, 0, got);
			burst(16);
		join
		chk(got, 8'h2f);
		chk(rdata, 8'h13);
		settle();
		chk({7'h0, coll_irq}, 8'h01);
		rd_chk(ADDR_ERR, 8'h01);
		rd_chk(ADDR_ERR, 8'h00);
		settle();
		chk({7'h0, coll_irq}, 8'h00);
		$display("collision done");
		complete_run();
	end
endmodule

// ===== verification/upar_link_model.sv
// behavioural ulpi link controller issuing register accesses
`timescale 1ns/1ps
module upar_link_model
	import upar_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       busy_i,
	input  wire logic       done_i,
	input  wire logic [7:0] rdata_i,
	output logic            req_o,
	output logic            we_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o
);
	initial begin
		{req_o, we_o, addr_o, wdata_o} = 18'h0;
	end
	// idles gap + 1 link cycles first; request held until taken, then lines inverted
	task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
		input int gap, output logic [7:0] rdata);
		int n;
		int m;
		repeat (gap + 1) @(posedge clk_i);
		#1;
		{req_o, we_o, addr_o, wdata_o} = {1'b1, we, addr, wdata};
		for (n = 0; n < 50 && busy_i; n++)
			@(posedge clk_i) #1;
		@(posedge clk_i) #1;
		{req_o, we_o, addr_o, wdata_o} = {1'b0, ~we, ~addr, ~wdata};
		for (m = 0; m < 50 && !done_i; m++)
			@(posedge clk_i) #1;
		rdata = rdata_i;
		if (n == 50 || m == 50) begin
			tb_upar_regs.miscompares++;
			tb_upar_regs.complete_run();
		end
	endtask
endmodule

// ===== verilog/upar_regs.sv
// usb phy auxiliary control register bank with i2c and ulpi access ports
//
// Behaviour
// - otg enable bit powers otg circuitry
// - test enables act only while otg off
// - set alias reads base, ones set bits
// - clear alias reads base, ones clear bits
// - force stop low when pin is gpio
// - polarity bit inverts serial transmit enable
// - four-pin serial mode select bit
// - route code picks processor interrupt line
// - enabled collision raises interrupt event
// - collision latch sticks until read
// - impedance trim two bits, reset zero
// - drive trim four bits, lsb boost
// - battery timer enable bit, reset zero
// - trim register reachable only over i2c
`timescale 1ns/1ps
module upar_regs
	import upar_pkg::*;
(
	input  wire logic       CLK_I,
	input  wire logic       SYS_RST_I,
	input  wire logic [7:0] I2C_ADDR_I,
	input  wire logic [7:0] I2C_WDATA_I,
	input  wire logic       I2C_WR_I,
	input  wire logic       I2C_RD_I,
	output logic      [7:0] I2C_RDATA_O,
	input  wire logic       ULPI_CLK_I,
	input  wire logic       LINK_RST_I,
	input  wire logic       ULPI_REQ_I,
	input  wire logic       ULPI_WE_I,
	input  wire logic [7:0] ULPI_ADDR_I,
	input  wire logic [7:0] ULPI_WDATA_I,
	output logic      [7:0] ULPI_RDATA_O,
	output logic            ULPI_DONE_O,
	output logic            ULPI_BUSY_O,
	input  wire logic       STOP_GPIO_MUX_I,
	input  wire logic       SERIAL_TX_ENABLE_I,
	input  wire logic       PHY_IRQ_I,
	input  wire logic       ALT_ROUTE_EN_I,
	output logic            OTG_BLOCK_ENABLE_O,
	output logic      [3:0] TEST_EN_O,
	output logic            STOP_FORCE_LOW_O,
	output logic            SERIAL_TX_ENABLE_O,
	output logic            FOUR_PIN_SERIAL_O,
	output logic            PROC1_IRQ_N_O,
	output logic            PROC2_IRQ_N_O,
	output logic            COLLISION_IRQ_O,
	output logic      [1:0] HS_IMPEDANCE_TRIM_O,
	output logic      [3:0] HS_DRIVE_TRIM_O,
	output logic            AC_BOOST_O,
	output logic            BATTERY_TIMER_EN_O
);

	function automatic upar_reg_t dec_reg(input logic [7:0] a);
		case (a)
			ADDR_PWR, ADDR_PWR_SET, ADDR_PWR_CLR:    dec_reg = REG_PWR;
			ADDR_IFC, ADDR_IFC_SET, ADDR_IFC_CLR:    dec_reg = REG_IFC;
			ADDR_EN, ADDR_EN_SET, ADDR_EN_CLR:       dec_reg = REG_EN;
			ADDR_ERR:                                dec_reg = REG_ERR;
			ADDR_TRIM, ADDR_TRIM_SET, ADDR_TRIM_CLR: dec_reg = REG_TRIM;
			default:                                 dec_reg = REG_NONE;
		endcase
	endfunction

	function automatic upar_op_t dec_op(input logic [7:0] a);
		case (a)
			ADDR_PWR_SET, ADDR_IFC_SET, ADDR_EN_SET, ADDR_TRIM_SET: dec_op = OP_SET;
			ADDR_PWR_CLR, ADDR_IFC_CLR, ADDR_EN_CLR, ADDR_TRIM_CLR: dec_op = OP_CLR;
			default:                                                dec_op = OP_BASE;
		endcase
	endfunction

	// one storage, three views; reserved bits never change
	function automatic logic [7:0] apply(input logic [7:0] cur, input logic [7:0] wd,
		input upar_op_t op, input logic [7:0] mask);
		case (op)
			OP_SET:  apply = cur | (wd & mask);
			OP_CLR:  apply = cur & ~(wd & mask);
			default: apply = wd & mask;
		endcase
	endfunction

	upar_main_t st_reg;
	upar_main_t st_next;
	upar_link_t lk_reg;
	upar_link_t lk_next;

	logic       i2c_acc;
	logic       req_evt;
	logic       collide;
	logic       ulpi_go;
	logic       irq_src;
	upar_acc_t  acc;
	upar_reg_t  rg;
	upar_op_t   op;
	logic [7:0] rd;
	logic       ack_evt;

	// register clock domain
	always_comb begin
		st_next = st_reg;
		i2c_acc = I2C_WR_I || I2C_RD_I;
		req_evt = (st_reg.req_sync[1] == st_reg.req_sync[2]) &&
			(st_reg.req_sync[2] != st_reg.req_seen);
		st_next.req_sync = {st_reg.req_sync[1:0], lk_reg.req_tgl};
		collide = i2c_acc && st_reg.ulpi_pend;
		ulpi_go = st_reg.ulpi_pend && !i2c_acc;
		acc = i2c_acc ? {I2C_WR_I, I2C_ADDR_I, I2C_WDATA_I} : st_reg.ulpi_acc;
		rg = dec_reg(acc.addr);
		if (ulpi_go && rg == REG_TRIM) begin
			rg = REG_NONE;
		end
		op = dec_op(acc.addr);
		case (rg)
			REG_PWR:  rd = st_reg.pwr;
			REG_IFC:  rd = st_reg.ifc;
			REG_EN:   rd = st_reg.en;
			REG_ERR:  rd = st_reg.err;
			REG_TRIM: rd = st_reg.trim;
			default:  rd = 8'h00;
		endcase
		if ((i2c_acc || ulpi_go) && acc.we) begin
			case (rg)
				REG_PWR:  st_next.pwr = apply(st_reg.pwr, acc.wdata, op, PWR_MASK);
				REG_IFC:  st_next.ifc = apply(st_reg.ifc, acc.wdata, op, IFC_MASK);
				REG_EN:   st_next.en = apply(st_reg.en, acc.wdata, op, EN_MASK);
				REG_TRIM: st_next.trim = apply(st_reg.trim, acc.wdata, op, TRIM_MASK);
				default:  st_next.err = st_reg.err;
			endcase
		end
		if ((i2c_acc || ulpi_go) && !acc.we && rg == REG_ERR) begin
			st_next.err = ERR_RST;
		end
		if (collide) begin
			st_next.err[COLL_BIT] = 1'b1;
		end
		if (I2C_RD_I) begin
			st_next.i2c_rdata = rd;
		end
		if (ulpi_go) begin
			st_next.ulpi_rdata = acc.we ? 8'h00 : rd;
			st_next.ulpi_pend = 1'b0;
			st_next.ack_tgl = ~st_reg.ack_tgl;
		end
		if (req_evt) begin
			st_next.req_seen = st_reg.req_sync[2];
			st_next.ulpi_pend = 1'b1;
			st_next.ulpi_acc = lk_reg.acc;
		end
		st_next.test_en = st_reg.pwr[OTG_ON_BIT] ? 4'h0 : st_reg.pwr[3:0];
		st_next.stop_low = st_reg.ifc[STOP_LOW_BIT] & STOP_GPIO_MUX_I;
		st_next.txen = SERIAL_TX_ENABLE_I ^ st_reg.ifc[TX_POL_BIT];
		st_next.coll_irq = st_reg.err[COLL_BIT] & st_reg.en[COLL_BIT];
		irq_src = PHY_IRQ_I | st_next.coll_irq;
		st_next.irq1_n = 1'b1;
		st_next.irq2_n = 1'b1;
		if (!ALT_ROUTE_EN_I) begin
			st_next.irq1_n = !irq_src;
		end else begin
			case (st_reg.ifc[ROUTE_LSB +: 2])
				ROUTE_PROC1: st_next.irq1_n = !irq_src;
				ROUTE_PROC2: st_next.irq2_n = !irq_src;
				default:     st_next.irq1_n = 1'b1;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			st_reg <= '0;
			st_reg.pwr <= PWR_RST;
			st_reg.ifc <= IFC_RST;
			st_reg.en <= EN_RST;
			st_reg.err <= ERR_RST;
			st_reg.trim <= TRIM_RST;
			st_reg.irq1_n <= 1'b1;
			st_reg.irq2_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// link clock domain
	always_comb begin
		lk_next = lk_reg;
		ack_evt = (lk_reg.ack_sync[1] == lk_reg.ack_sync[2]) &&
			(lk_reg.ack_sync[2] != lk_reg.ack_seen);
		lk_next.ack_sync = {lk_reg.ack_sync[1:0], st_reg.ack_tgl};
		lk_next.done = 1'b0;
		if (ack_evt) begin
			lk_next.ack_seen = lk_reg.ack_sync[2];
			lk_next.busy = 1'b0;
			lk_next.done = 1'b1;
			lk_next.rdata = st_reg.ulpi_rdata;
		end else if (ULPI_REQ_I && !lk_reg.busy) begin
			lk_next.busy = 1'b1;
			lk_next.req_tgl = ~lk_reg.req_tgl;
			lk_next.acc = {ULPI_WE_I, ULPI_ADDR_I, ULPI_WDATA_I};
		end
	end

	always_ff @(posedge ULPI_CLK_I) begin
		if (LINK_RST_I) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	assign I2C_RDATA_O = st_reg.i2c_rdata;
	assign ULPI_RDATA_O = lk_reg.rdata;
	assign ULPI_DONE_O = lk_reg.done;
	assign ULPI_BUSY_O = lk_reg.busy;
	assign OTG_BLOCK_ENABLE_O = st_reg.pwr[OTG_ON_BIT];
	assign TEST_EN_O = st_reg.test_en;
	assign STOP_FORCE_LOW_O = st_reg.stop_low;
	assign SERIAL_TX_ENABLE_O = st_reg.txen;
	assign FOUR_PIN_SERIAL_O = st_reg.ifc[FOUR_PIN_BIT];
	assign PROC1_IRQ_N_O = st_reg.irq1_n;
	assign PROC2_IRQ_N_O = st_reg.irq2_n;
	assign COLLISION_IRQ_O = st_reg.coll_irq;
	assign HS_IMPEDANCE_TRIM_O = st_reg.trim[ZTRIM_LSB +: 2];
	assign HS_DRIVE_TRIM_O = st_reg.trim[ITRIM_LSB +: 4];
	assign AC_BOOST_O = st_reg.trim[ITRIM_LSB];
	assign BATTERY_TIMER_EN_O = st_reg.trim[VBAT_BIT];

	// checks in the register clock domain
	a_otg_enable_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_WR_I && I2C_ADDR_I == ADDR_PWR_SET && I2C_WDATA_I[OTG_ON_BIT]) |=>
		OTG_BLOCK_ENABLE_O)
		else $error("otg enable not set by set alias");

	a_test_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		st_reg.pwr[OTG_ON_BIT] |=> TEST_EN_O == 4'h0)
		else $error("test enable active while otg enabled");

	a_set_alias_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_WR_I && I2C_ADDR_I == ADDR_PWR_SET) |=>
		st_reg.pwr == ($past(st_reg.pwr) | ($past(I2C_WDATA_I) & PWR_MASK)))
		else $error("set alias write wrong");

	a_set_alias_read: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_RD_I && !I2C_WR_I && I2C_ADDR_I == ADDR_PWR_SET) |=>
		I2C_RDATA_O == $past(st_reg.pwr))
		else $error("set alias read wrong");

	a_clear_alias_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_WR_I && I2C_ADDR_I == ADDR_IFC_CLR) |=>
		st_reg.ifc == ($past(st_reg.ifc) & ~($past(I2C_WDATA_I) & IFC_MASK)))
		else $error("clear alias write wrong");

	a_stop_force: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(st_reg.ifc[STOP_LOW_BIT] && STOP_GPIO_MUX_I) |=> STOP_FORCE_LOW_O)
		else $error("stop not forced low");

	a_tx_polarity: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(st_reg.ifc[TX_POL_BIT] && SERIAL_TX_ENABLE_I) |=> !SERIAL_TX_ENABLE_O)
		else $error("transmit enable polarity wrong");

	a_route_second: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(ALT_ROUTE_EN_I && st_reg.ifc[1:0] == ROUTE_PROC2 && PHY_IRQ_I) |=>
		(!PROC2_IRQ_N_O && PROC1_IRQ_N_O))
		else $error("interrupt not routed to second line");

	a_collision_irq: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(st_reg.err[COLL_BIT] && st_reg.en[COLL_BIT]) |=> COLLISION_IRQ_O)
		else $error("collision interrupt missing");

	a_latch_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(i2c_acc && st_reg.ulpi_pend) |=> st_reg.err[COLL_BIT] [*1] ##1 1'b1)
		else $error("collision latch not set");

	a_latch_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_RD_I && !I2C_WR_I && I2C_ADDR_I == ADDR_ERR && !st_reg.ulpi_pend) |=>
		(I2C_RDATA_O == $past(st_reg.err)) && !st_reg.err[COLL_BIT])
		else $error("collision latch not cleared by read");

	a_trim_private: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(ulpi_go && dec_reg(st_reg.ulpi_acc.addr) == REG_TRIM) |=> $stable(st_reg.trim))
		else $error("ulpi access changed trim register");

	a_reserved_zero: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		((st_reg.pwr & ~PWR_MASK) == 8'h00) && ((st_reg.ifc & ~IFC_MASK) == 8'h00) &&
		((st_reg.en & ~EN_MASK) == 8'h00) && ((st_reg.trim & ~TRIM_MASK) == 8'h00))
		else $error("reserved bit set");

	a_trim_reset: assert property (@(posedge CLK_I)
		$fell(SYS_RST_I) |-> st_reg.trim == TRIM_RST)
		else $error("trim reset value wrong");

	a_otg_enable_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_WR_I && I2C_ADDR_I == ADDR_PWR_CLR && I2C_WDATA_I[OTG_ON_BIT]) |=>
		!OTG_BLOCK_ENABLE_O)
		else $error("otg enable not cleared by clear alias");

	a_four_pin_mode: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_WR_I && I2C_ADDR_I == ADDR_IFC) |=>
		FOUR_PIN_SERIAL_O == $past(I2C_WDATA_I[FOUR_PIN_BIT]))
		else $error("four pin select wrong");

	a_route_first: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(ALT_ROUTE_EN_I && st_reg.ifc[1:0] == ROUTE_PROC1 && PHY_IRQ_I) |=>
		(!PROC1_IRQ_N_O && PROC2_IRQ_N_O))
		else $error("interrupt not routed to first line");

	a_route_default: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(!ALT_ROUTE_EN_I && PHY_IRQ_I) |=> (!PROC1_IRQ_N_O && PROC2_IRQ_N_O))
		else $error("interrupt not on first line without reroute");

	a_route_reserved: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(ALT_ROUTE_EN_I && st_reg.ifc[1]) |=> (PROC1_IRQ_N_O && PROC2_IRQ_N_O))
		else $error("reserved route code drove a line");

	a_collision_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		!st_reg.en[COLL_BIT] |=> !COLLISION_IRQ_O)
		else $error("collision interrupt while disabled");

	a_ulpi_trim_read: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(ulpi_go && !st_reg.ulpi_acc.we && dec_reg(st_reg.ulpi_acc.addr) == REG_TRIM) |=>
		st_reg.ulpi_rdata == 8'h00)
		else $error("ulpi read of trim register not zero");

	a_trim_fields: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(I2C_WR_I && I2C_ADDR_I == ADDR_TRIM) |=>
		(HS_IMPEDANCE_TRIM_O == $past(I2C_WDATA_I[ZTRIM_LSB +: 2])) &&
		(HS_DRIVE_TRIM_O == $past(I2C_WDATA_I[ITRIM_LSB +: 4])) &&
		(AC_BOOST_O == $past(I2C_WDATA_I[ITRIM_LSB])) &&
		(BATTERY_TIMER_EN_O == $past(I2C_WDATA_I[VBAT_BIT])))
		else $error("trim outputs do not follow write");

	// link side request handshake
	sequence s_link_take;
		ULPI_REQ_I && !ULPI_BUSY_O;
	endsequence

	sequence s_link_finish;
		ULPI_BUSY_O ##[2:12] ULPI_DONE_O;
	endsequence

	a_link_handshake: assert property (@(posedge ULPI_CLK_I) disable iff (LINK_RST_I)
		s_link_take |=> s_link_finish)
		else $error("ulpi access not finished in time");

endmodule
